// File: design/rbm_pkg.sv
package rbm_pkg;

   localparam logic [3:0] STRAP_SLAVE_I2C = 4'h0;
   localparam logic [3:0] STRAP_EEPROM = 4'h1;
   localparam logic [3:0] STRAP_FLASH = 4'h2;

   localparam int CLK_HZ = 10_000_000;
   localparam int XTAL_NOMINAL_HZ = 24_576_000;
   localparam int EEPROM_BPS = 400_000;
   localparam int FLASH_HZ = 1_530_000;
   localparam int SLAVE_DEV_ADDR = 88;
   localparam logic [6:0] SLAVE_DEV_ADDR_7 = 7'(SLAVE_DEV_ADDR);

   // half-period counts; longest time rounds down, never below one
   localparam int EEPROM_HALF_CYC_RAW = CLK_HZ / (2 * EEPROM_BPS);
   localparam int EEPROM_HALF_CYC = (EEPROM_HALF_CYC_RAW < 1) ? 1 : EEPROM_HALF_CYC_RAW;
   localparam int FLASH_HALF_CYC_RAW = CLK_HZ / (2 * FLASH_HZ);
   localparam int FLASH_HALF_CYC = (FLASH_HALF_CYC_RAW < 1) ? 1 : FLASH_HALF_CYC_RAW;

   localparam logic [3:0] RESET_STRAP = 4'h0;

   typedef enum logic [3:0] {
      RBM_RST = 4'b0001,
      RBM_CAPT = 4'b0010,
      RBM_BOOT = 4'b0100,
      RBM_BAD = 4'b1000
   } rbm_state_e;

   // boot source selection as seen by the rest of the chip
   typedef struct packed {
      logic slave_i2c1;
      logic master_i2c0;
      logic master_spi;
      logic reserved;
   } rbm_boot_sel_s;

   typedef struct packed {
      logic bod_33;
      logic bod_18;
      logic por;
   } rbm_supply_s;

endpackage : rbm_pkg

// File: design/rbm_reset_boot.sv
`timescale 1ns/1ps
`default_nettype none
module rbm_reset_boot (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic sys_reset_in_low,
   input wire logic [3:0] boot_strap,
   input wire rbm_pkg::rbm_supply_s supply,
   input wire logic boot_done,
   output logic reset_out_low_od_oe,
   output logic reset_out_low_od_o,
   output logic core_rst_n,
   output logic pll_enable,
   output logic xtal_enable,
   output logic boot_start,
   output logic booting,
   output var rbm_pkg::rbm_boot_sel_s boot_sel,
   output logic [3:0] boot_mode,
   output logic [6:0] slave_dev_addr,
   output logic i2c1_host_ctrl,
   output logic i2c0_boot_master,
   output logic i2c_multi_master,
   output logic spi_enable,
   output logic decrypt_allowed,
   output logic amp_shutdown,
   output logic boot_tick
);

   logic rst_s1_r, rst_s2_r;
   logic [3:0] strap_s1_r, strap_s2_r;
   rbm_pkg::rbm_supply_s sup_s1_r, sup_s2_r;
   rbm_pkg::rbm_state_e state_r, state_nxt;
   logic [3:0] mode_r;
   logic [7:0] div_r;
   logic fault_now;

   // pins are asynchronous: two flops before any use
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
         strap_s1_r <= rbm_pkg::RESET_STRAP;
         strap_s2_r <= rbm_pkg::RESET_STRAP;
         sup_s1_r <= '1;
         sup_s2_r <= '1;
      end else begin
         rst_s1_r <= sys_reset_in_low;
         rst_s2_r <= rst_s1_r;
         strap_s1_r <= boot_strap;
         strap_s2_r <= strap_s1_r;
         sup_s1_r <= supply;
         sup_s2_r <= sup_s1_r;
      end
   end

   assign fault_now = sup_s2_r.por | sup_s2_r.bod_33 | sup_s2_r.bod_18;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         rbm_pkg::RBM_RST: if (rst_s2_r && !fault_now) state_nxt = rbm_pkg::RBM_CAPT;
         rbm_pkg::RBM_CAPT: begin
            if (strap_s2_r > rbm_pkg::STRAP_FLASH) state_nxt = rbm_pkg::RBM_BAD;
            else state_nxt = rbm_pkg::RBM_BOOT;
         end
         rbm_pkg::RBM_BOOT: state_nxt = rbm_pkg::RBM_BOOT;
         rbm_pkg::RBM_BAD: state_nxt = rbm_pkg::RBM_BAD;
         default: state_nxt = rbm_pkg::RBM_RST;
      endcase
      if (!rst_s2_r || fault_now) state_nxt = rbm_pkg::RBM_RST;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) state_r <= rbm_pkg::RBM_RST;
      else state_r <= state_nxt;
   end

   // mode latched once at release, frozen after
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) mode_r <= rbm_pkg::RESET_STRAP;
      else if (state_r == rbm_pkg::RBM_RST) mode_r <= rbm_pkg::RESET_STRAP;
      else if (state_r == rbm_pkg::RBM_CAPT) mode_r <= strap_s2_r;
   end

   // reset-side outputs
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reset_out_low_od_oe <= 1'b1;
         core_rst_n <= 1'b0;
         pll_enable <= 1'b0;
         amp_shutdown <= 1'b1;
      end else begin
         reset_out_low_od_oe <= fault_now;
         core_rst_n <= (state_nxt != rbm_pkg::RBM_RST);
         pll_enable <= (state_nxt != rbm_pkg::RBM_RST);
         // droop cuts amps at once, before firmware can react
         amp_shutdown <= fault_now || (state_nxt == rbm_pkg::RBM_RST);
      end
   end

   // boot-side outputs
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         boot_start <= 1'b0;
         booting <= 1'b0;
         boot_sel <= '0;
         boot_mode <= rbm_pkg::RESET_STRAP;
         spi_enable <= 1'b0;
      end else begin
         boot_start <= (state_r == rbm_pkg::RBM_CAPT) && (state_nxt == rbm_pkg::RBM_BOOT);
         boot_mode <= (state_nxt == rbm_pkg::RBM_RST) ? rbm_pkg::RESET_STRAP : mode_r;
         if (state_nxt == rbm_pkg::RBM_RST || boot_done) booting <= 1'b0;
         else if (state_r == rbm_pkg::RBM_CAPT && state_nxt == rbm_pkg::RBM_BOOT) booting <= 1'b1;
         if (state_r == rbm_pkg::RBM_BOOT) begin
            boot_sel.slave_i2c1 <= (mode_r == rbm_pkg::STRAP_SLAVE_I2C);
            boot_sel.master_i2c0 <= (mode_r == rbm_pkg::STRAP_EEPROM);
            boot_sel.master_spi <= (mode_r == rbm_pkg::STRAP_FLASH);
            boot_sel.reserved <= 1'b0;
         end else if (state_r == rbm_pkg::RBM_BAD) begin
            boot_sel <= '0;
            boot_sel.reserved <= 1'b1;
         end else begin
            boot_sel <= '0;
         end
         // spi only while a flash boot is in progress
         spi_enable <= booting && !boot_done && (state_nxt == rbm_pkg::RBM_BOOT)
                       && (mode_r == rbm_pkg::STRAP_FLASH);
      end
   end

   // port roles: fixed slave address, the rest follow reset and boot state
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         slave_dev_addr <= 7'h00;
         i2c1_host_ctrl <= 1'b0;
         i2c0_boot_master <= 1'b0;
         i2c_multi_master <= 1'b0;
         decrypt_allowed <= 1'b0;
      end else begin
         slave_dev_addr <= rbm_pkg::SLAVE_DEV_ADDR_7;
         i2c1_host_ctrl <= core_rst_n;
         i2c0_boot_master <= (state_r == rbm_pkg::RBM_BOOT) && (mode_r == rbm_pkg::STRAP_EEPROM);
         i2c_multi_master <= core_rst_n;
         decrypt_allowed <= (state_r == rbm_pkg::RBM_BOOT);
      end
   end

   // serial clock enable for the selected master boot source
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         div_r <= 8'h00;
         boot_tick <= 1'b0;
      end else if (state_r != rbm_pkg::RBM_BOOT || !booting) begin
         div_r <= 8'h00;
         boot_tick <= 1'b0;
      end else if ((mode_r == rbm_pkg::STRAP_EEPROM && div_r == 8'(rbm_pkg::EEPROM_HALF_CYC - 1)) ||
                   (mode_r == rbm_pkg::STRAP_FLASH && div_r == 8'(rbm_pkg::FLASH_HALF_CYC - 1))) begin
         div_r <= 8'h00;
         boot_tick <= 1'b1;
      end else begin
         div_r <= (mode_r == rbm_pkg::STRAP_SLAVE_I2C) ? 8'h00 : div_r + 8'h01;
         boot_tick <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         reset_out_low_od_o <= 1'b0;
         xtal_enable <= 1'b1;
      end else begin
         reset_out_low_od_o <= 1'b0;
         xtal_enable <= 1'b1;
      end
   end

   chk_od_follows_fault: assert property (@(posedge clk) disable iff (!arst_n)
      fault_now |=> reset_out_low_od_oe) else $error("reset out not pulled low");
   chk_pll_off_reset: assert property (@(posedge clk) disable iff (!arst_n)
      !rst_s2_r |=> !pll_enable && !core_rst_n) else $error("pll on in reset");
   chk_mode_frozen: assert property (@(posedge clk) disable iff (!arst_n)
      (state_r == rbm_pkg::RBM_BOOT && $past(state_r) == rbm_pkg::RBM_BOOT) |-> $stable(mode_r))
      else $error("mode changed");
   chk_bad_code: assert property (@(posedge clk) disable iff (!arst_n)
      (state_r == rbm_pkg::RBM_CAPT && strap_s2_r > rbm_pkg::STRAP_FLASH && rst_s2_r && !fault_now)
      |=> ##1 boot_sel.reserved && !boot_start) else $error("reserved code booted");
   sequence s_capture;
      state_r == rbm_pkg::RBM_CAPT && strap_s2_r <= rbm_pkg::STRAP_FLASH && rst_s2_r && !fault_now;
   endsequence
   chk_boot_start: assert property (@(posedge clk) disable iff (!arst_n)
      s_capture |=> boot_start ##1 !boot_start) else $error("boot start missing");
   chk_eeprom_sel: assert property (@(posedge clk) disable iff (!arst_n)
      (s_capture ##1 mode_r == rbm_pkg::STRAP_EEPROM && state_r == rbm_pkg::RBM_BOOT && rst_s2_r && !fault_now)
      |=> boot_sel.master_i2c0) else $error("eeprom not selected");
   chk_amp_off: assert property (@(posedge clk) disable iff (!arst_n)
      fault_now |=> amp_shutdown) else $error("amp not shut down");
   chk_spi_only_boot: assert property (@(posedge clk) disable iff (!arst_n)
      spi_enable |-> mode_r == rbm_pkg::STRAP_FLASH && $past(booting)) else $error("spi outside boot");
   chk_fault_holds_core: assert property (@(posedge clk) disable iff (!arst_n)
      fault_now |=> !core_rst_n && !pll_enable) else $error("core released during supply fault");
   chk_spi_done_off: assert property (@(posedge clk) disable iff (!arst_n)
      boot_done |=> !spi_enable) else $error("spi still on after boot end");
   chk_slave_sel: assert property (@(posedge clk) disable iff (!arst_n)
      (state_r == rbm_pkg::RBM_BOOT && mode_r == rbm_pkg::STRAP_SLAVE_I2C) |=> boot_sel.slave_i2c1)
      else $error("slave boot not selected");

endmodule : rbm_reset_boot
`default_nettype wire

// File: tb/rbm_board.sv
`timescale 1ns/1ps
`default_nettype none
module rbm_board #(
   parameter int DONE_CYC = 40
) (
   input wire logic clk,
   input wire logic rst_btn_n,
   input wire logic [3:0] strap_code,
   input wire logic reset_out_low_od_oe,
   input wire logic booting,
   output wire logic sys_reset_in_low,
   output wire logic [3:0] boot_strap,
   output logic boot_done
);
   int cnt;
   // pull-up node shared by button and open-drain reset out
   assign sys_reset_in_low = rst_btn_n & ~reset_out_low_od_oe;
   // resistors set the code; a changed code models a rework after capture
   assign boot_strap = strap_code;
   // slow loader: image ends well after the boot source runs
   always @(posedge clk) begin
      cnt <= booting ? cnt + 1 : 0;
      boot_done <= booting && (cnt >= DONE_CYC);
   end
endmodule : rbm_board
`default_nettype wire

// File: tb/rbm_reset_boot_test.sv
`timescale 1ns/1ps
`default_nettype none
module rbm_reset_boot_test;
   logic clk = 1'b0;
   logic arst_n, rst_btn_n, sys_reset_in_low, boot_done, oe, od_o, core_rst_n, pll_enable, xtal_enable;
   logic boot_start, booting, i2c1_host_ctrl, i2c0_boot_master, i2c_multi_master, spi_enable;
   logic decrypt_allowed, amp_shutdown, boot_tick;
   logic [3:0] strap_code, boot_strap, boot_mode;
   logic [6:0] slave_dev_addr;
   rbm_pkg::rbm_supply_s supply;
   rbm_pkg::rbm_boot_sel_s boot_sel;
   int miscompares = 0, n_checks = 0, cyc = 0, n_starts = 0, last_tick = 0, tick_gap = 0;
   int sel_q[$] = '{8, 4, 2};

   rbm_reset_boot uut (.clk(clk), .arst_n(arst_n), .sys_reset_in_low(sys_reset_in_low),
      .boot_strap(boot_strap), .supply(supply), .boot_done(boot_done), .reset_out_low_od_oe(oe),
      .reset_out_low_od_o(od_o), .core_rst_n(core_rst_n), .pll_enable(pll_enable),
      .xtal_enable(xtal_enable), .boot_start(boot_start), .booting(booting), .boot_sel(boot_sel),
      .boot_mode(boot_mode), .slave_dev_addr(slave_dev_addr), .i2c1_host_ctrl(i2c1_host_ctrl),
      .i2c0_boot_master(i2c0_boot_master), .i2c_multi_master(i2c_multi_master),
      .spi_enable(spi_enable), .decrypt_allowed(decrypt_allowed), .amp_shutdown(amp_shutdown),
      .boot_tick(boot_tick));
   rbm_board board (.clk(clk), .rst_btn_n(rst_btn_n), .strap_code(strap_code),
      .reset_out_low_od_oe(oe), .booting(booting), .sys_reset_in_low(sys_reset_in_low),
      .boot_strap(boot_strap), .boot_done(boot_done));

   always #50 clk = ~clk;

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (boot_start === 1'b1) n_starts <= n_starts + 1;
      if (boot_tick === 1'b1) begin
         tick_gap <= cyc - last_tick;
         last_tick <= cyc;
      end
   end

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic give_verdict;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : give_verdict

   task automatic boot_with(input logic [3:0] c);
      int s0;
      rst_btn_n = 1'b0;
      strap_code = c;
      repeat (4) @(negedge clk);
      chk("pll_xtal", {pll_enable, xtal_enable}, 8'h01);
      chk("core_rst", core_rst_n, 8'h00);
      s0 = n_starts;
      rst_btn_n = 1'b1;
      repeat (8) @(negedge clk);
      chk("mode", boot_mode, 8'(c));
      chk("starts", 8'(n_starts - s0), 8'(c < 3));
      chk("sel", boot_sel, 8'(c < 3 ? sel_q[c] : 1));
      chk("addr", slave_dev_addr, 8'd88);
      chk("ports", {i2c1_host_ctrl, i2c_multi_master, i2c0_boot_master}, {6'h3, c == 1});
      chk("spi", spi_enable, 8'(c == 2));
      chk("decrypt", decrypt_allowed, 8'(c < 3));
      chk("amp", amp_shutdown, 8'h00);
      chk("pll_on", pll_enable, 8'h01);
      strap_code = 4'($urandom);
      // two slow ticks must fall in the window so the gap is measured within this boot
      repeat (30) @(negedge clk);
      if (c == 1) chk("tick", 8'(tick_gap), 8'(rbm_pkg::EEPROM_HALF_CYC));
      if (c == 2) chk("tick", 8'(tick_gap), 8'(rbm_pkg::FLASH_HALF_CYC));
      chk("held", boot_mode, 8'(c));
      repeat (40) @(negedge clk);
      chk("spi_off", {booting, spi_enable}, 8'h00);
   endtask : boot_with

   initial begin
      arst_n = 1'b0;
      rst_btn_n = 1'b1;
      strap_code = 4'h0;
      supply = '0;
      void'($urandom(32'hb62eaa77));
      repeat (5) @(negedge clk);
      arst_n = 1'b1;
      for (int i = 0; i < 16; i++) boot_with(4'(i));
      boot_with(4'h1);
      // droop after the boot has finished, on one random detector
      supply = 3'(1 << ($urandom % 3));
      repeat (4) @(negedge clk);
      chk("reset_out", {oe, od_o}, 8'h02);
      chk("amp", amp_shutdown, 8'h01);
      chk("core_rst", core_rst_n, 8'h00);
      supply = '0;
      strap_code = 4'h2;
      repeat (16) @(negedge clk);
      chk("rebooted", {boot_mode, core_rst_n, amp_shutdown}, 8'h0a);
      give_verdict();
   end

   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      give_verdict();
   end
endmodule : rbm_reset_boot_test
`default_nettype wire
